// File: cic_core.sv
`timescale 1ns/100ps
module cic_core #(
  parameter logic [5:0] ANDLIT_PREFIX = cic_pkg::PX_ANDLIT_DEF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic [13:0] instr_in,
  input  wire logic        wake_in,
  output logic      [14:0] pc_out,
  output logic             fetch_out,
  output logic      [7:0]  w_out,
  output logic             zero_flag_out,
  output logic             carry_flag_out,
  output logic             digit_carry_flag_out,
  output logic             timeout_flag_out,
  output logic             powerdown_flag_out,
  output logic             irq_enable_out,
  output logic      [7:0]  option_out,
  output logic      [63:0] dir_out,
  output logic      [15:0] ptr0_out,
  output logic      [15:0] ptr1_out,
  output logic             wdt_clear_out,
  output logic             standby_out,
  output logic             soft_reset_out
);
  import cic_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sext6(input logic [5:0] k);
    sext6 = {{10{k[5]}}, k};
  endfunction : sext6

  function automatic logic [15:0] step(input logic [15:0] p,
                                       input logic        dec);
    step = dec ? p - 16'h0001 : p + 16'h0001;
  endfunction : step

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cic_state_t  state_q;
  logic        phase_q;
  logic [13:0] ir_q;
  logic [15:0] ea_q;
  logic [14:0] pc_q;
  logic [7:0]  w_q;
  logic        z_q, c_q, dc_q, to_q, pd_q, gie_q;
  logic [7:0]  option_q;
  logic [63:0] dir_q;
  logic [15:0] ptr0_q, ptr1_q;
  logic [3:0]  sp_q;
  logic        standby_q, wdt_clr_q, swrst_q;
  logic [7:0]  ram_rdata;
  logic [14:0] stk_rdata;

  // ----------------------------------------------------------------
  // fetch side: effective data address from the incoming word
  // ----------------------------------------------------------------
  wire         run        = !standby_q;
  wire         fetch      = run && !phase_q && (state_q == ST_EXEC);
  wire         f_mm       = (instr_in[13:4] == PX_MMANY);
  wire         f_idx      = (instr_in[13:8] == PX_IDXANY);
  wire         f_and      = (instr_in[13:8] == PX_ANDREG);
  wire  [15:0] f_pmm      = instr_in[2] ? ptr1_q : ptr0_q;
  wire  [15:0] f_pidx     = instr_in[6] ? ptr1_q : ptr0_q;
  wire  [15:0] f_pmm_ea   = instr_in[1] ? f_pmm : step(f_pmm, instr_in[0]);
  wire  [15:0] f_idx_ea   = f_pidx + sext6(instr_in[5:0]);
  wire         f_indport  = (instr_in[6:1] == 6'h00);
  wire  [15:0] f_pfile    = instr_in[0] ? ptr1_q : ptr0_q;
  wire  [15:0] f_and_ea   = f_indport ? f_pfile : {9'h000, instr_in[6:0]};
  wire  [15:0] ea_fetch   = f_mm  ? f_pmm_ea :
                            f_idx ? f_idx_ea :
                            f_and ? f_and_ea : 16'h0000;

  // ----------------------------------------------------------------
  // execute side decode
  // ----------------------------------------------------------------
  wire fire       = run && phase_q && (state_q == ST_EXEC);
  wire op_swrst   = (ir_q == OP_SWRESET);
  wire op_ret     = (ir_q == OP_RETURN);
  wire op_retirq  = (ir_q == OP_RETIRQ);
  wire op_callacc = (ir_q == OP_CALLACC);
  wire op_bracc   = (ir_q == OP_BRACC);
  wire op_option  = (ir_q == OP_OPTION);
  wire op_sleep   = (ir_q == OP_SLEEP);
  wire op_wdtclr  = (ir_q == OP_WDTCLR);
  // codes 2..4 of the direction load group are taken by the ops above
  wire op_dirld   = (ir_q[13:3] == PX_DIRLD) && !op_option
                    && !op_sleep && !op_wdtclr;
  wire op_ldmm    = (ir_q[13:3] == PX_LDMM);
  wire op_stmm    = (ir_q[13:3] == PX_STMM);
  wire op_padd    = (ir_q[13:7] == PX_PADD);
  wire op_ldidx   = (ir_q[13:7] == PX_LDIDX);
  wire op_stidx   = (ir_q[13:7] == PX_STIDX);
  wire op_retlit  = (ir_q[13:8] == PX_RETLIT);
  wire op_addlit  = (ir_q[13:8] == PX_ADDLIT);
  wire op_andlit  = (ir_q[13:8] == ANDLIT_PREFIX);
  wire op_andreg  = (ir_q[13:8] == PX_ANDREG);
  wire op_relbr   = (ir_q[13:9] == PX_RELBR);
  wire op_call    = (ir_q[13:11] == PX_CALL);
  wire op_jump    = (ir_q[13:11] == PX_JUMP);

  wire op_pop     = op_ret || op_retirq || op_retlit;
  wire op_push    = op_call || op_callacc;
  wire pc_chg     = op_pop || op_push || op_jump || op_bracc || op_relbr;
  wire uses_ind   = op_ldmm || op_stmm || op_ldidx || op_stidx
                    || (op_andreg && (ir_q[6:1] == 6'h00));
  wire extra      = uses_ind && ea_q[15];

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  wire [7:0]  lit      = ir_q[7:0];
  wire [14:0] pc_inc   = pc_q + 15'h0001;
  wire [14:0] pc_bracc = pc_inc + {7'h00, w_q};
  wire [14:0] pc_rel   = pc_inc + {{6{ir_q[8]}}, ir_q[8:0]};
  wire [14:0] pc_abs   = {pc_q[14:11], ir_q[10:0]};
  wire [14:0] pc_cacc  = {pc_q[14:8], w_q};
  wire [14:0] pc_d     = op_bracc   ? pc_bracc :
                         op_callacc ? pc_cacc :
                         (op_call || op_jump) ? pc_abs :
                         op_relbr   ? pc_rel :
                         op_pop     ? stk_rdata : pc_inc;

  wire [7:0]  and_lit  = w_q & lit;
  wire [7:0]  and_reg  = w_q & ram_rdata;
  wire [8:0]  sum9     = {1'b0, w_q} + {1'b0, lit};
  wire [4:0]  sum_lo   = {1'b0, w_q[3:0]} + {1'b0, lit[3:0]};
  wire        op_ld    = op_ldmm || op_ldidx;
  wire        and_to_w = op_andreg && !ir_q[7];
  wire        w_we     = op_retlit || op_andlit || op_addlit || op_ld
                         || and_to_w;
  wire [7:0]  w_d      = op_retlit ? lit :
                         op_andlit ? and_lit :
                         op_addlit ? sum9[7:0] :
                         op_ld     ? ram_rdata : and_reg;
  wire        z_we     = op_andlit || op_addlit || op_ld || op_andreg;
  wire [7:0]  z_src    = op_andlit ? and_lit :
                         op_addlit ? sum9[7:0] :
                         op_ld     ? ram_rdata : and_reg;

  wire        ram_we   = fire && (op_stmm || op_stidx // RQ18 RQ19
                                  || (op_andreg && ir_q[7]));
  wire [7:0]  ram_wd   = op_andreg ? and_reg : w_q;

  wire        ptr_n    = (op_ldmm || op_stmm) ? ir_q[2] : ir_q[6];
  wire [15:0] ptr_cur  = ptr_n ? ptr1_q : ptr0_q;
  wire        ptr_we   = fire && (op_padd || op_ldmm || op_stmm);
  wire [15:0] padd_k   = sext6(ir_q[5:0]);
  wire [15:0] ptr_new  = op_padd ? ptr_cur + padd_k
                                 : step(ptr_cur, ir_q[0]);

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  cic_ram #(.W(8), .AW(DAW)) u_data (
    .clk_in    (ref_clk_in),
    .we_in     (ram_we),
    .waddr_in  (ea_q[6:0]),
    .wdata_in  (ram_wd),
    .re_in     (fetch),
    .raddr_in  (ea_fetch[6:0]),
    .rdata_out (ram_rdata)
  );

  cic_ram #(.W(PCW), .AW(SAW)) u_stack (
    .clk_in    (ref_clk_in),
    .we_in     (fire && op_push),
    .waddr_in  (sp_q),
    .wdata_in  (pc_inc),
    .re_in     (fetch),
    .raddr_in  (sp_q - 4'h1),
    .rdata_out (stk_rdata)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      phase_q <= 1'b0;
      state_q <= ST_EXEC;
    end else if (run) begin
      phase_q <= !phase_q;
      if (phase_q) begin
        case (state_q)
          ST_EXEC:  state_q <= pc_chg ? ST_FLUSH :       // RQ1 RQ24
                               extra  ? ST_EXTRA : ST_EXEC; // RQ2
          ST_FLUSH: state_q <= ST_EXEC;
          ST_EXTRA: state_q <= ST_EXEC;
          default:  state_q <= ST_EXEC;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ir_q <= OP_NOP;
      ea_q <= 16'h0000;
    end else if (fetch) begin
      ir_q <= instr_in;
      ea_q <= ea_fetch;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pc_q <= RST_PC;
      sp_q <= RST_SP;
    end else if (fire) begin
      pc_q <= pc_d; // RQ3 RQ4 RQ5 RQ6 RQ7 RQ23 RQ24 RQ25
      if (op_push) begin
        sp_q <= sp_q + 4'h1; // RQ24 RQ4
      end else if (op_pop) begin
        sp_q <= sp_q - 4'h1; // RQ7
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulator and status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      w_q  <= 8'h00;
      z_q  <= 1'b0;
      c_q  <= 1'b0;
      dc_q <= 1'b0;
    end else if (fire) begin
      if (w_we) begin
        w_q <= w_d; // RQ6 RQ16 RQ17 RQ20 RQ21 RQ22
      end
      if (z_we) begin
        z_q <= (z_src == 8'h00); // RQ16 RQ17 RQ20 RQ21 RQ22
      end
      if (op_addlit) begin
        c_q  <= sum9[8]; // RQ21
        dc_q <= sum_lo[4];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      to_q      <= 1'b1;
      pd_q      <= 1'b1;
      gie_q     <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      if (fire && (op_wdtclr || op_sleep)) begin
        to_q <= 1'b1; // RQ8 RQ11
        pd_q <= op_wdtclr;
      end
      if (fire && op_retirq) begin
        gie_q <= 1'b1; // RQ5
      end
      if (fire && op_sleep) begin
        standby_q <= 1'b1; // RQ11
      end else if (wake_in) begin
        standby_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wdt_clr_q <= 1'b0;
      swrst_q   <= 1'b0;
    end else begin
      wdt_clr_q <= fire && op_wdtclr; // RQ8
      swrst_q   <= fire && op_swrst; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // configuration and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      option_q <= RST_OPTION;
      dir_q    <= RST_DIR;
    end else if (fire) begin
      if (op_option) begin
        option_q <= w_q; // RQ9
      end
      if (op_dirld) begin
        dir_q[{ir_q[2:0], 3'b000} +: 8] <= w_q; // RQ12
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ptr0_q <= RST_PTR;
      ptr1_q <= RST_PTR;
    end else if (ptr_we) begin
      if (ptr_n) begin
        ptr1_q <= ptr_new; // RQ13 RQ14 RQ15 RQ16 RQ18
      end else begin
        ptr0_q <= ptr_new; // RQ13 RQ14 RQ15 RQ16 RQ18
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pc_out               = pc_q;
  assign fetch_out            = fetch;
  assign w_out                = w_q;
  assign zero_flag_out        = z_q;
  assign carry_flag_out       = c_q;
  assign digit_carry_flag_out = dc_q;
  assign timeout_flag_out     = to_q;
  assign powerdown_flag_out   = pd_q;
  assign irq_enable_out       = gie_q;
  assign option_out           = option_q;
  assign dir_out              = dir_q;
  assign ptr0_out             = ptr0_q;
  assign ptr1_out             = ptr1_q;
  assign wdt_clear_out        = wdt_clr_q;
  assign standby_out          = standby_q;
  assign soft_reset_out       = swrst_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_pc_flush: assert property (fire && pc_chg |=> // RQ1
    state_q == ST_FLUSH ##1 state_q == ST_FLUSH ##1 state_q == ST_EXEC)
    else $error("pc change not followed by idle cycle");
  a_extra_cycle: assert property (fire && extra |=> // RQ2
    state_q == ST_EXTRA [*2] ##1 state_q == ST_EXEC)
    else $error("missing extra indirect cycle");
  a_bracc_target: assert property (fire && op_bracc |=> // RQ3
    pc_q == $past(pc_q) + 15'h0001 + {7'h00, $past(w_q)})
    else $error("accumulator branch target wrong");
  a_callacc_push: assert property (fire && op_callacc |=> // RQ4
    pc_q == {$past(pc_q[14:8]), $past(w_q)} && sp_q == $past(sp_q) + 4'h1)
    else $error("accumulator call wrong");
  a_retirq_gie: assert property (fire && op_retirq |=> // RQ5
    gie_q && pc_q == $past(stk_rdata))
    else $error("interrupt return wrong");
  a_retlit_w: assert property (fire && op_retlit |=> // RQ6
    w_q == $past(lit) && pc_q == $past(stk_rdata))
    else $error("literal return wrong");
  a_return_pop: assert property (fire && op_ret |=> // RQ7
    sp_q == $past(sp_q) - 4'h1)
    else $error("return did not pop");
  a_wdtclr_flags: assert property (fire && op_wdtclr |=> // RQ8
    to_q && pd_q && wdt_clear_out ##1 !wdt_clear_out)
    else $error("watchdog clear wrong");
  a_option_load: assert property (fire && op_option |=> // RQ9
    option_out == $past(w_q))
    else $error("option load wrong");
  a_soft_reset: assert property (fire && op_swrst |=> // RQ10
    soft_reset_out)
    else $error("no soft reset pulse");
  a_sleep_flags: assert property (fire && op_sleep |=> // RQ11
    to_q && !pd_q && standby_out)
    else $error("standby entry wrong");
  a_padd_wrap: assert property (fire && op_padd |=> // RQ13
    ptr_cur == $past(ptr_cur) + $past(padd_k) && z_q == $past(z_q))
    else $error("pointer add wrong");
  a_addlit_flags: assert property (fire && op_addlit |=> // RQ21
    w_q == $past(sum9[7:0]) && c_q == $past(sum9[8]) && z_q == (w_q == 8'h00))
    else $error("literal add wrong");
  a_nop_single: assert property (fire && ir_q == OP_NOP |=> // RQ25
    state_q == ST_EXEC && pc_q == $past(pc_inc))
    else $error("no operation wrong");

endmodule : cic_core

// File: cic_pkg.sv
//
// Operation
// RQ1: pc-changing instructions take two instruction cycles, second one idle
// RQ2: indirect access with pointer top bit set adds one instruction cycle
// RQ3: opcode 000B branches relative by accumulator, two cycles
// RQ4: opcode 000A calls target built from accumulator, two cycles
// RQ5: opcode 0009 returns from interrupt service, two cycles
// RQ6: 11 0100 kkkkkkkk returns and loads literal into accumulator
// RQ7: opcode 0008 pops return address, two cycles
// RQ8: opcode 0064 clears watchdog, sets timeout and powerdown flags, one cycle
// RQ9: opcode 0062 copies accumulator to option register, one cycle
// RQ10: opcode 0001 triggers software reset of whole device
// RQ11: opcode 0063 enters standby, updates timeout and powerdown flags
// RQ12: 00 0000 0110 0fff loads direction register fff from accumulator
// RQ13: 11 0001 0nkkkkkk adds literal to pointer n, no flags
// RQ14: pointer literal is signed -32..31, added to full 16-bit pair
// RQ15: pointer wraps modulo 16 bits at both ends
// RQ16: indirect load with mm pre/post inc/dec into accumulator, updates Z
// RQ17: indexed load pointer n plus offset, pointer kept, updates Z
// RQ18: indirect store with mm pre/post inc/dec, flags kept
// RQ19: indexed store at pointer n plus offset, pointer and flags kept
// RQ20: literal AND into accumulator, only Z updated
// RQ21: literal add into accumulator, updates C, DC and Z
// RQ22: AND accumulator with location 0..127, d picks destination, updates Z
// RQ23: relative branch by signed 9-bit literal from incremented pc
// RQ24: absolute call and jump take two cycles; call pushes return address
// RQ25: all-zero opcode does nothing in one instruction cycle
//
package cic_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int IW         = 14;
  localparam int PCW        = 15;
  localparam int PTRW       = 16;
  localparam int DAW        = 7;
  localparam int DDEPTH     = 128;
  localparam int SAW        = 4;
  localparam int SDEPTH     = 16;

  // ----------------------------------------------------------------
  // exact opcodes
  // ----------------------------------------------------------------
  localparam logic [13:0] OP_NOP     = 14'h0000;
  localparam logic [13:0] OP_SWRESET = 14'h0001;
  localparam logic [13:0] OP_RETURN  = 14'h0008;
  localparam logic [13:0] OP_RETIRQ  = 14'h0009;
  localparam logic [13:0] OP_CALLACC = 14'h000A;
  localparam logic [13:0] OP_BRACC   = 14'h000B;
  localparam logic [13:0] OP_OPTION  = 14'h0062;
  localparam logic [13:0] OP_SLEEP   = 14'h0063;
  localparam logic [13:0] OP_WDTCLR  = 14'h0064;

  // ----------------------------------------------------------------
  // opcode prefixes, compared against the top bits
  // ----------------------------------------------------------------
  localparam logic [10:0] PX_DIRLD   = 11'h00C;
  localparam logic [10:0] PX_LDMM    = 11'h002;
  localparam logic [10:0] PX_STMM    = 11'h003;
  localparam logic [6:0]  PX_PADD    = 7'h62;
  localparam logic [6:0]  PX_LDIDX   = 7'h7E;
  localparam logic [6:0]  PX_STIDX   = 7'h7F;
  localparam logic [5:0]  PX_RETLIT  = 6'h34;
  localparam logic [5:0]  PX_ADDLIT  = 6'h3E;
  localparam logic [5:0]  PX_ANDREG  = 6'h05;
  localparam logic [5:0]  PX_IDXANY  = 6'h3F;
  localparam logic [9:0]  PX_MMANY   = 10'h001;
  localparam logic [4:0]  PX_RELBR   = 5'h19;
  localparam logic [2:0]  PX_CALL    = 3'h4;
  localparam logic [2:0]  PX_JUMP    = 3'h5;
  localparam logic [5:0]  PX_ANDLIT_DEF = 6'h39;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [14:0] RST_PC     = 15'h0000;
  localparam logic [7:0]  RST_OPTION = 8'hFF;
  localparam logic [63:0] RST_DIR    = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [15:0] RST_PTR    = 16'h0000;
  localparam logic [3:0]  RST_SP     = 4'h0;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01,
    ST_EXTRA = 2'b10
  } cic_state_t;

endpackage : cic_pkg

// File: cic_prog_mem_model.sv
`timescale 1ns/100ps
module cic_prog_mem_model (
  input  wire logic [14:0] pc_in,
  input  wire logic        fetch_in,
  output logic      [13:0] instr_out
);
  // ------------------------------------------------------------
  // program store, valid only in the fetch clock
  // ------------------------------------------------------------
  logic [13:0] mem_q [64];
  assign instr_out = fetch_in ? mem_q[pc_in[5:0]] : ~mem_q[pc_in[5:0]];
  task automatic put(input logic [5:0] a, input logic [13:0] d);
    mem_q[a] = d;
  endtask : put
endmodule : cic_prog_mem_model

// File: cic_ram.sv
`timescale 1ns/100ps
module cic_ram #(
  parameter int W  = 8,
  parameter int AW = 7
) (
  input  wire logic          clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [W-1:0]  wdata_in,
  input  wire logic          re_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [W-1:0]  rdata_out
);

  logic [W-1:0] mem_q [2**AW];

  // ----------------------------------------------------------------
  // write port and registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (re_in) begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule : cic_ram

// File: testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin \
  n_tests++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); \
  end \
end
module testbench;
  import cic_pkg::*;
  typedef struct packed {
    logic [5:0]  a;
    logic [13:0] op;
    logic [7:0]  w;
    logic [2:0]  f;
    logic [1:0]  p;
    logic [2:0]  g;
  } cic_row_t;
  // ------------------------------------------------------------
  // address, word, acc, z/c/dc, wdt/soft pulses, clocks to next
  // ------------------------------------------------------------
  localparam int NR = 38;
  localparam cic_row_t ROWS [NR] = '{
    '{6'd0,  14'h3E37, 8'h37, 3'b000, 2'b00, 3'd2},
    '{6'd1,  14'h3EC9, 8'h00, 3'b111, 2'b00, 3'd2},
    '{6'd2,  14'h3E0F, 8'h0F, 3'b000, 2'b00, 3'd2},
    '{6'd3,  14'h393C, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd4,  14'h0062, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd5,  14'h0065, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd6,  14'h313F, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd7,  14'h3160, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd8,  14'h0018, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd9,  14'h3900, 8'h00, 3'b100, 2'b00, 3'd2},
    '{6'd10, 14'h3F00, 8'h0C, 3'b000, 2'b00, 3'd2},
    '{6'd11, 14'h001F, 8'h0C, 3'b000, 2'b00, 3'd4},
    '{6'd12, 14'h3FFF, 8'h0C, 3'b000, 2'b00, 3'd4},
    '{6'd13, 14'h0014, 8'h0C, 3'b000, 2'b00, 3'd4},
    '{6'd14, 14'h3900, 8'h00, 3'b100, 2'b00, 3'd2},
    '{6'd15, 14'h0580, 8'h00, 3'b100, 2'b00, 3'd2},
    '{6'd16, 14'h3E05, 8'h05, 3'b000, 2'b00, 3'd2},
    '{6'd17, 14'h0500, 8'h00, 3'b100, 2'b00, 3'd2},
    '{6'd18, 14'h0064, 8'h00, 3'b100, 2'b10, 3'd2},
    '{6'd19, 14'h3202, 8'h00, 3'b100, 2'b00, 3'd4},
    '{6'd22, 14'h3E03, 8'h03, 3'b000, 2'b00, 3'd2},
    '{6'd23, 14'h000B, 8'h03, 3'b000, 2'b00, 3'd4},
    '{6'd27, 14'h3E1B, 8'h1E, 3'b000, 2'b00, 3'd2},
    '{6'd28, 14'h000A, 8'h1E, 3'b000, 2'b00, 3'd4},
    '{6'd30, 14'h3455, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd29, 14'h2820, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd32, 14'h2024, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd36, 14'h0008, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd33, 14'h2026, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd38, 14'h0009, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd34, 14'h0000, 8'h55, 3'b000, 2'b00, 3'd2},
    '{6'd35, 14'h2827, 8'h55, 3'b000, 2'b00, 3'd4},
    '{6'd39, 14'h0001, 8'h55, 3'b000, 2'b01, 3'd2},
    '{6'd40, 14'h001A, 8'h55, 3'b000, 2'b00, 3'd2},
    '{6'd41, 14'h3900, 8'h00, 3'b100, 2'b00, 3'd2},
    '{6'd42, 14'h0011, 8'h55, 3'b000, 2'b00, 3'd2},
    '{6'd43, 14'h0560, 8'h04, 3'b000, 2'b00, 3'd2},
    '{6'd44, 14'h0063, 8'h04, 3'b000, 2'b00, 3'd2}
  };
  logic        ref_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic        wake_in    = 1'b0;
  logic [13:0] instr;
  logic [14:0] pc_out;
  logic [7:0]  w_out, option;
  logic [63:0] dir;
  logic [15:0] ptr0, ptr1;
  logic        fetch, zf, cf, dcf, tof, pdf, gie, wdt_clr, stby, swrst;
  logic [4:0]  cnt;
  logic [12:0] res, exp_v;
  int          fails   = 0;
  int          n_tests = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  cic_prog_mem_model pm (.pc_in(pc_out), .fetch_in(fetch),
    .instr_out(instr));
  cic_core uut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .instr_in(instr), .wake_in(wake_in), .pc_out(pc_out),
    .fetch_out(fetch), .w_out(w_out), .zero_flag_out(zf),
    .carry_flag_out(cf), .digit_carry_flag_out(dcf),
    .timeout_flag_out(tof), .powerdown_flag_out(pdf),
    .irq_enable_out(gie), .option_out(option), .dir_out(dir),
    .ptr0_out(ptr0), .ptr1_out(ptr1), .wdt_clear_out(wdt_clr),
    .standby_out(stby), .soft_reset_out(swrst));
  task automatic step();
    @(negedge ref_clk_in);
    cnt++;
  endtask : step
  task automatic wait_fetch();
    while (fetch !== 1'b1 && cnt < 5'd20) begin
      step();
    end
  endtask : wait_fetch
  task automatic end_sim();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // watchdog, about sixteen times the expected run
  // ------------------------------------------------------------
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    fails++;
    end_sim();
  end
  initial begin
    cnt = 5'd0;
    for (int i = 0; i < 64; i++) begin
      pm.put(6'(i), 14'h0000);
    end
    foreach (ROWS[i]) begin
      pm.put(ROWS[i].a, ROWS[i].op);
    end
    repeat (8) @(negedge ref_clk_in);
    `CHK({pc_out, w_out, ptr0, ptr1}, 55'h0)
    `CHK({option, dir, tof, pdf, gie}, {{9{8'hFF}}, 3'b110})
    $display("test reset done");
    srst_in = 1'b0;
    foreach (ROWS[i]) begin
      wait_fetch();
      if (i > 0) `CHK(cnt, 5'(ROWS[i-1].g))
      `CHK(pc_out, 15'(ROWS[i].a))
      cnt = 5'd0;
      step();
      step();
      res   = {w_out, zf, cf, dcf, wdt_clr, swrst};
      exp_v = {ROWS[i].w, ROWS[i].f, ROWS[i].p};
      `CHK(res, exp_v)
    end
    $display("test instruction rows done");
    `CHK({ptr0, ptr1}, 32'h0000_FFE0)
    `CHK({option, dir[47:40]}, 16'h0C0C)
    `CHK({dir[63:48], dir[39:0]}, 56'hFF_FFFF_FFFF_FFFF)
    `CHK({stby, tof, pdf, gie}, 4'b1101)
    repeat (6) step();
    `CHK(fetch, 1'b0)
    wake_in = 1'b1;
    step();
    wake_in = 1'b0;
    cnt = 5'd0;
    wait_fetch();
    `CHK({stby, pc_out}, {1'b0, 15'd45})
    $display("test standby done");
    srst_in = 1'b1;
    step();
    step();
    `CHK({pc_out, w_out, gie, tof, pdf}, {23'h0, 3'b011})
    srst_in = 1'b0;
    step();
    step();
    `CHK({pc_out, w_out}, {15'd1, 8'h37})
    $display("test second reset done");
    end_sim();
  end
endmodule : testbench
